//--- rtl/nfh_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module nfh_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_r;
    reg [AW-1:0] rdPtr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != {(AW+1){1'b0}});
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
        if (reset) begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // nfh_fifo

//--- rtl/nfh_host.v
// host-side nand flash pin sequencer with write-data fifo
`timescale 1ns/1ps
`include "nfh_map.vh"
module nfh_host #(
    parameter BUS_W = 8,
    parameter STROBE_CYC = `NFH_STROBE_CYC,
    parameter BUSY_TIMEOUT = `NFH_BUSY_TIMEOUT_CYC,
    parameter FIFO_DEPTH = 8
) (
    input wire clk,
    input wire reset,
    input wire [2:0] opCode,
    input wire [15:0] opCount,
    input wire opValid,
    output wire opReady,
    input wire [BUS_W-1:0] opByte,
    input wire [BUS_W-1:0] wrData,
    input wire wrValid,
    output wire wrReady,
    output reg [BUS_W-1:0] rdData,
    output reg rdValid,
    output reg timeoutFlag,
    output reg chip_select_n,
    output reg cmd_latch_strobe,
    output reg addr_latch_strobe,
    output reg write_strobe_n,
    output reg output_strobe_n,
    output reg [BUS_W-1:0] shared_bus_o,
    output reg shared_bus_oe_n,
    input wire [BUS_W-1:0] shared_bus_i,
    input wire ready_busy_n,
    output reg modify_lock_n,
    input wire lockRequest,
    output reg [13:0] eccCode
);
    // ==========================================================================
    // states
    localparam ST_IDLE = 3'h0;
    localparam ST_LOW = 3'h1;
    localparam ST_HIGH = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_GAP = 3'h4;
    // last unit index of one correction span
    localparam ECC_LAST = `NFH_ECC_SPAN_BYTES * 8 / BUS_W - 1;

    reg [2:0] state_r;
    reg [2:0] op_r;
    reg [15:0] left_r;
    reg [BUS_W-1:0] byte_r;
    reg [23:0] timer_r;
    reg [BUS_W-1:0] busMeta_r;
    reg [BUS_W-1:0] busSync_r;
    reg rbMeta_r;
    reg rbSync_r;
    reg lockMeta_r;
    wire [BUS_W-1:0] fifoData;
    wire fifoValid;
    wire fifoPop;
    reg [13:0] eccAcc_r;
    reg [9:0] eccPos_r;

    function [23:0] strobeLen;
        input dummy;
        begin
            strobeLen = STROBE_CYC[23:0] - 24'h1;
        end
    endfunction

    // position code: xor of the one-based positions of all set bits, with overall parity on top;
    // a single flipped bit shows up as its own position, so one bit per span can be corrected
    function [13:0] eccFold;
        input [13:0] acc;
        input [BUS_W-1:0] unit;
        input [9:0] idx;
        integer b;
        integer posWide;
        begin
            eccFold = acc;
            for (b = 0; b < BUS_W; b = b + 1) begin
                posWide = idx * BUS_W + b + 1;
                if (unit[b]) begin
                    eccFold = {~eccFold[13], eccFold[12:0] ^ posWide[12:0]};
                end
            end
        end
    endfunction

    // ==========================================================================
    // synchronisers: bus and ready/busy come from an unclocked device
    always @(posedge clk) begin
        if (reset) begin
            busMeta_r <= {BUS_W{1'b0}};
            busSync_r <= {BUS_W{1'b0}};
            rbMeta_r <= 1'b1;
            rbSync_r <= 1'b1;
            lockMeta_r <= 1'b0;
            modify_lock_n <= 1'b0;
        end else begin
            busMeta_r <= shared_bus_i;
            busSync_r <= busMeta_r;
            rbMeta_r <= ready_busy_n; // see R11
            rbSync_r <= rbMeta_r;
            lockMeta_r <= lockRequest;
            modify_lock_n <= ~lockMeta_r; // see R10 see R19
        end
    end

    nfh_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH), .AW(3)) wrFifo (
        .clk(clk),
        .reset(reset),
        .inData(wrData),
        .inValid(wrValid),
        .inReady(wrReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    assign opReady = (state_r == ST_IDLE);
    // write unit leaves the fifo as its strobe cycle starts; stalls when empty
    assign fifoPop = (state_r == ST_GAP) && (op_r == `NFH_OP_WRITE) && fifoValid && (timer_r == 24'h0);

    // ==========================================================================
    // write-side correction code, one code per span of written units
    always @(posedge clk) begin
        if (reset) begin
            eccAcc_r <= 14'h0;
            eccPos_r <= 10'h0;
            eccCode <= 14'h0;
        end else if (fifoPop) begin
            if (eccPos_r == ECC_LAST[9:0]) begin
                eccCode <= eccFold(eccAcc_r, fifoData, eccPos_r); // see R16
                eccAcc_r <= 14'h0;
                eccPos_r <= 10'h0;
            end else begin
                eccAcc_r <= eccFold(eccAcc_r, fifoData, eccPos_r); // see R16
                eccPos_r <= eccPos_r + 10'h1;
            end
        end else if (opReady && opValid && (opCode == `NFH_OP_CMD) && (eccPos_r != 10'h0)) begin
            // a command closes a short span, so a page tail still gets its code
            eccCode <= eccAcc_r; // see R16
            eccAcc_r <= 14'h0;
            eccPos_r <= 10'h0;
        end
    end

    // ==========================================================================
    // sequencer
    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            op_r <= `NFH_OP_IDLE;
            left_r <= 16'h0;
            byte_r <= {BUS_W{1'b0}};
            timer_r <= 24'h0;
            rdData <= {BUS_W{1'b0}};
            rdValid <= 1'b0;
            timeoutFlag <= 1'b0;
            chip_select_n <= 1'b1;
            cmd_latch_strobe <= 1'b0;
            addr_latch_strobe <= 1'b0;
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
            shared_bus_o <= {BUS_W{1'b0}};
            shared_bus_oe_n <= 1'b1;
        end else begin
            rdValid <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    cmd_latch_strobe <= 1'b0;
                    addr_latch_strobe <= 1'b0;
                    shared_bus_oe_n <= 1'b1;
                    if (opValid) begin
                        op_r <= opCode;
                        left_r <= (opCount == 16'h0) ? 16'h1 : opCount;
                        byte_r <= opByte;
                        timer_r <= 24'h0;
                        timeoutFlag <= 1'b0;
                        chip_select_n <= 1'b0; // see R1
                        if (opCode == `NFH_OP_WAIT) begin
                            timer_r <= 24'h2; // let busy reach the synchroniser
                            state_r <= ST_WAIT;
                        end else begin
                            state_r <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (timer_r != 24'h0) begin
                        timer_r <= timer_r - 24'h1;
                    end else if (op_r != `NFH_OP_WRITE || fifoValid) begin
                        cmd_latch_strobe <= (op_r == `NFH_OP_CMD); // see R17
                        addr_latch_strobe <= (op_r == `NFH_OP_ADDR); // see R17
                        // one bus for command, address and data, x8 or x16
                        shared_bus_o <= (op_r == `NFH_OP_WRITE) ? fifoData : byte_r; // see R2
                        shared_bus_oe_n <= (op_r == `NFH_OP_READ); // see R2
                        if (op_r == `NFH_OP_READ) begin
                            output_strobe_n <= 1'b0; // see R18
                        end else begin
                            write_strobe_n <= 1'b0; // see R1
                        end
                        timer_r <= strobeLen(1'b0);
                        state_r <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (timer_r != 24'h0) begin
                        timer_r <= timer_r - 24'h1;
                    end else begin
                        if (op_r == `NFH_OP_READ) begin
                            output_strobe_n <= 1'b1; // see R8
                            // one extra high cycle so the unit has cleared both bus sync stages
                            timer_r <= strobeLen(1'b0) + 24'h1;
                        end else begin
                            write_strobe_n <= 1'b1; // rising edge latches, see R17
                            timer_r <= strobeLen(1'b0);
                        end
                        state_r <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (timer_r != 24'h0) begin
                        timer_r <= timer_r - 24'h1;
                    end else begin
                        if (op_r == `NFH_OP_READ) begin
                            rdData <= busSync_r; // see R18
                            rdValid <= 1'b1;
                        end
                        if (left_r == 16'h1) begin
                            state_r <= ST_IDLE;
                        end else begin
                            left_r <= left_r - 16'h1;
                            byte_r <= byte_r + 1'b1; // consecutive address or command bytes
                            state_r <= ST_GAP;
                        end
                    end
                end
                ST_WAIT: begin
                    // host stays off the bus until the device releases busy
                    shared_bus_oe_n <= 1'b1;
                    if (timer_r != 24'h0 && timer_r < 24'h3) begin
                        timer_r <= timer_r - 24'h1;
                    end else if (rbSync_r) begin
                        state_r <= ST_IDLE; // see R20
                    end else if (timer_r >= BUSY_TIMEOUT[23:0]) begin
                        timeoutFlag <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        timer_r <= (timer_r == 24'h0) ? 24'h3 : timer_r + 24'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // nfh_host

//--- rtl/nfh_map.vh
// constants, pin timing and sizes for the nand flash host controller
// ==========================================================================
// Operation
// R1 - host marks every command, address and data transfer with select and strobes
// R2 - one shared bus carries commands, addresses and data both ways, x8 or x16
// R3 - byte array: 2048 blocks of 64 pages, 2048+64 bytes per page
// R4 - word array: 1024 blocks of 64 pages, 1K+32 words per page
// R5 - block erase takes about 2ms and clears one 128K byte block
// R6 - page program writes a 2112 byte page in about 200us
// R7 - page read into the register finishes within 25us
// R8 - sequential read cycle at least 30ns per unit, paced by output strobe
// R9 - device runs program and erase internally without host help
// R10 - lock input blocks program and erase regardless of commands
// R11 - ready/busy is open drain and may be wired with other devices
// R12 - toggling select during a read does not abort it
// R13 - copy-back programs internal data to another page without resending
// R14 - cache program takes new data while the previous page programs
// R15 - signature read returns five successive cycles
// R16 - host applies at least one bit per 528 bytes error correction
// R17 - write strobe rising edge latches command or address per latch strobes
// R18 - each output strobe falling edge drives next unit, advances column
// R19 - low lock level rejects program and erase
// R20 - device holds busy low during array work; host waits for release
`ifndef NFH_MAP_VH
`define NFH_MAP_VH

// ==========================================================================
// sizes
`define NFH_PAGE_MAIN_BYTES 2048
`define NFH_PAGE_SPARE_BYTES 64
`define NFH_PAGE_BYTES 2112
`define NFH_PAGE_MAIN_WORDS 1024
`define NFH_PAGE_SPARE_WORDS 32
`define NFH_PAGES_PER_BLOCK 64
`define NFH_BLOCKS_X8 2048
`define NFH_BLOCKS_X16 1024
`define NFH_ID_CYCLES 5
`define NFH_ECC_SPAN_BYTES 528

// ==========================================================================
// timing (ns) and the clock period
`define NFH_CLK_NS 50
`define NFH_SEQ_CYCLE_NS 30
`define NFH_READ_MAX_NS 25000
`define NFH_PROG_TYP_NS 200000
`define NFH_ERASE_TYP_NS 2000000
// least times round up, none below one cycle
`define NFH_CEILCYC(t) ((((t) + `NFH_CLK_NS - 1) / `NFH_CLK_NS) < 1 ? 1 : (((t) + `NFH_CLK_NS - 1) / `NFH_CLK_NS))
`define NFH_STROBE_CYC `NFH_CEILCYC(`NFH_SEQ_CYCLE_NS)
// busy timeout: erase typical times four, a generous watchdog
`define NFH_BUSY_TIMEOUT_CYC (4 * `NFH_ERASE_TYP_NS / `NFH_CLK_NS)

// ==========================================================================
// host operations
`define NFH_OP_CMD 3'h0
`define NFH_OP_ADDR 3'h1
`define NFH_OP_WRITE 3'h2
`define NFH_OP_READ 3'h3
`define NFH_OP_WAIT 3'h4
`define NFH_OP_IDLE 3'h7

`endif

//--- sim/nfh_flash_model.sv
// behavioural nand flash device facing the host controller
`timescale 1ns/1ps
module nfh_flash_model #(
    parameter READ_CYC = 20,
    parameter PROG_CYC = 40,
    parameter ERASE_CYC = 300
) (
    input wire clk,
    input wire cmd_latch_strobe,
    input wire addr_latch_strobe,
    input wire write_strobe_n,
    input wire output_strobe_n,
    input wire modify_lock_n,
    input wire [7:0] busIn,
    output logic [7:0] busOut = 8'h00,
    output wire ready_busy_n,
    output logic [7:0] lastData = 8'h00,
    output int progCount = 0
);
    logic weOld = 1'b1;
    logic reOld = 1'b1;
    logic [11:0] col = 12'h000; // wide enough for a whole page
    int busy = 0;
    int hold = 0;
    // released open drain: the pull-up wins
    assign ready_busy_n = (busy == 0);
    // sampled mid-cycle since the host moves its pins just after the rising edge
    always @(negedge clk) begin
        weOld <= write_strobe_n;
        reOld <= output_strobe_n;
        if (busy > 0) busy <= busy - 1;
        if (write_strobe_n && !weOld) begin
            if (cmd_latch_strobe) begin
                col <= 12'h000;
                if (busIn == 8'h30) busy <= READ_CYC;
                // copy-back ends with this same confirm
                if (busIn == 8'h10 && modify_lock_n) begin
                    busy <= PROG_CYC;
                    progCount <= progCount + 1;
                end
                if (busIn == 8'hd0 && modify_lock_n) busy <= ERASE_CYC;
            end else if (!addr_latch_strobe) lastData <= busIn;
        end
        if (!output_strobe_n && reOld) begin
            busOut <= 8'h5a + col[7:0];
            col <= col + 12'h001;
            hold <= 3;
        end else if (hold > 0) hold <= hold - 1;
        else busOut <= ~busOut;
    end
endmodule // nfh_flash_model

//--- sim/nfh_host_properties.sv
// concurrent checks on the nand flash host controller pins
`timescale 1ns/1ps
module nfh_host_properties (
    input wire clk,
    input wire reset,
    input wire opReady,
    input wire rdValid,
    input wire chip_select_n,
    input wire cmd_latch_strobe,
    input wire addr_latch_strobe,
    input wire write_strobe_n,
    input wire output_strobe_n,
    input wire shared_bus_oe_n,
    input wire modify_lock_n,
    input wire lockRequest
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ==========================================================================
    // assertions
    property p_lock_on; lockRequest [*5] |-> !modify_lock_n; endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock pin not asserted");
    property p_lock_off; !lockRequest [*5] |-> modify_lock_n; endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock pin not released");
    property p_latch_excl; $rose(write_strobe_n) |-> !(cmd_latch_strobe && addr_latch_strobe); endproperty
    a_latch_excl: assert property (p_latch_excl) else $error("both latch strobes high");
    property p_wr_drive; !write_strobe_n |-> !shared_bus_oe_n && !chip_select_n; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("bus not driven on write");
    property p_rd_release; !output_strobe_n |-> shared_bus_oe_n && !chip_select_n; endproperty
    a_rd_release: assert property (p_rd_release) else $error("bus driven on read");
    property p_rd_width; $fell(output_strobe_n) |=> output_strobe_n [*2]; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe timing");
    property p_wr_width; $fell(write_strobe_n) |=> write_strobe_n [*2]; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe timing");
    property p_rd_valid; $rose(output_strobe_n) |-> ##[0:3] rdValid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("no read data pulse");
    property p_idle_quiet; opReady |-> write_strobe_n && output_strobe_n; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe active when idle");
    c_write: cover property ($fell(write_strobe_n));
    c_read: cover property ($fell(output_strobe_n));
    c_lock: cover property ($fell(modify_lock_n));
endmodule // nfh_host_properties

bind nfh_host nfh_host_properties i_nfh_host_properties (.clk(clk), .reset(reset), .opReady(opReady),
    .rdValid(rdValid), .chip_select_n(chip_select_n), .cmd_latch_strobe(cmd_latch_strobe),
    .addr_latch_strobe(addr_latch_strobe), .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
    .shared_bus_oe_n(shared_bus_oe_n), .modify_lock_n(modify_lock_n), .lockRequest(lockRequest));

//--- sim/test_nand_flash_device_interface.sv
// self-checking bench for the nand flash host controller
`timescale 1ns/1ps
`include "nfh_map.vh"
module test_nand_flash_device_interface;
    localparam PROG_CYC = 40;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] opCode = 3'h7;
    logic [15:0] opCount = 16'h0000;
    logic opValid = 1'b0;
    logic [7:0] opByte = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic wrValid = 1'b0;
    logic lockRequest = 1'b0;
    wire opReady, wrReady, rdValid, timeoutFlag, csN, cle, ale, weN, reN, oeN, rbN, lockN;
    wire [7:0] rdData, busHost, busDev, lastData;
    wire [13:0] eccCode;
    int progCount;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] rdQ[$];
    wire [7:0] busLevel = !oeN ? busHost : busDev;
    nfh_host #(.BUS_W(8), .BUSY_TIMEOUT(200)) i_nfh_host (.clk(clk), .reset(reset), .opCode(opCode),
        .opCount(opCount), .opValid(opValid), .opReady(opReady), .opByte(opByte), .wrData(wrData),
        .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData), .rdValid(rdValid), .timeoutFlag(timeoutFlag),
        .chip_select_n(csN), .cmd_latch_strobe(cle), .addr_latch_strobe(ale), .write_strobe_n(weN),
        .output_strobe_n(reN), .shared_bus_o(busHost), .shared_bus_oe_n(oeN), .shared_bus_i(busLevel),
        .ready_busy_n(rbN), .modify_lock_n(lockN), .lockRequest(lockRequest), .eccCode(eccCode));
    nfh_flash_model #(.PROG_CYC(PROG_CYC)) i_nfh_flash_model (.clk(clk), .cmd_latch_strobe(cle),
        .addr_latch_strobe(ale), .write_strobe_n(weN), .output_strobe_n(reN), .modify_lock_n(lockN),
        .busIn(busLevel), .busOut(busDev), .ready_busy_n(rbN), .lastData(lastData), .progCount(progCount));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        if (rdValid === 1'b1) rdQ.push_back(rdData);
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            give_verdict;
        end
    end
    // ==========================================================================
    // shared tasks
    task automatic tick;
        @(posedge clk);
        #5;
    endtask
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic do_op(input logic [2:0] code, input logic [15:0] cnt, input logic [7:0] val);
        while (opReady !== 1'b1) tick;
        opCode = code;
        opCount = cnt;
        opByte = val;
        opValid = 1'b1;
        tick;
        opValid = 1'b0;
    endtask
    task automatic wait_ready(output int cyc);
        do_op(`NFH_OP_WAIT, 16'h0001, 8'h00);
        cyc = 0;
        while (opReady !== 1'b1) begin
            tick;
            cyc++;
        end
    endtask
    task automatic read_check(input int n);
        rdQ.delete();
        do_op(`NFH_OP_READ, 16'(n), 8'h00);
        while (opReady !== 1'b1) tick;
        repeat (3) tick;
        check("read count", 16'(rdQ.size()), 16'(n));
        foreach (rdQ[i]) check("read data", {8'h00, rdQ[i]}, {8'h00, 8'h5a + 8'(i)});
    endtask
    task automatic program_page(output int cyc);
        int k;
        k = 0;
        wrValid = 1'b1;
        wrData = 8'h30;
        while (wrReady === 1'b1 && k < 9) begin
            tick;
            k++;
            wrData = 8'h30 + 8'h03 * k[7:0];
        end
        wrValid = 1'b0;
        check("fifo fill", 16'(k), 16'd8);
        do_op(`NFH_OP_CMD, 16'h0001, 8'h80);
        do_op(`NFH_OP_ADDR, 16'h0005, 8'h00);
        do_op(`NFH_OP_WRITE, 16'h0008, 8'h00);
        do_op(`NFH_OP_CMD, 16'h0001, 8'h10);
        wait_ready(cyc);
        check("fifo drained", {15'h0, wrReady}, 16'h0001);
    endtask
    // ==========================================================================
    // scenarios
    task automatic t_read_id;
        do_op(`NFH_OP_CMD, 16'h0001, 8'h90);
        do_op(`NFH_OP_ADDR, 16'h0001, 8'h00);
        read_check(5);
    endtask
    task automatic t_page_read;
        int cyc;
        do_op(`NFH_OP_CMD, 16'h0001, 8'h00);
        do_op(`NFH_OP_ADDR, 16'h0005, 8'h00);
        do_op(`NFH_OP_CMD, 16'h0001, 8'h30);
        wait_ready(cyc);
        check("read busy", {15'h0, cyc >= 15}, 16'h0001);
        read_check(3);
    endtask
    task automatic t_program;
        int cyc;
        int n0;
        n0 = progCount;
        program_page(cyc);
        check("programs", 16'(progCount), 16'(n0 + 1));
        check("last data", {8'h00, lastData}, 16'h0045);
        check("ecc code", {2'b00, eccCode}, 16'h203c);
        check("prog busy", {15'h0, cyc >= PROG_CYC - 5}, 16'h0001);
        check("no timeout", {15'h0, timeoutFlag}, 16'h0000);
    endtask
    task automatic t_locked;
        int cyc;
        int n0;
        n0 = progCount;
        lockRequest = 1'b1;
        repeat (5) tick;
        check("lock pin", {15'h0, lockN}, 16'h0000);
        program_page(cyc);
        check("locked program", 16'(progCount), 16'(n0));
        lockRequest = 1'b0;
        repeat (5) tick;
        check("unlock pin", {15'h0, lockN}, 16'h0001);
    endtask
    task automatic t_erase_timeout;
        int cyc;
        do_op(`NFH_OP_CMD, 16'h0001, 8'h60);
        do_op(`NFH_OP_ADDR, 16'h0003, 8'h00);
        do_op(`NFH_OP_CMD, 16'h0001, 8'hd0);
        wait_ready(cyc);
        check("busy timeout", {15'h0, timeoutFlag}, 16'h0001);
        repeat (150) tick;
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #5;
        reset = 1'b0;
        t_read_id;
        t_page_read;
        t_program;
        t_locked;
        t_erase_timeout;
        give_verdict;
    end
endmodule // test_nand_flash_device_interface
